// *** common/cfs_pkg.sv ***
// Package for the converter fault supervisor: timing constants, states, carriers.
// Assumes a 100 MHz clock; analog comparators deliver clean synchronous verdicts.
package cfs_pkg;
   localparam int CLK_MHZ            = 100;            // Clock rate in MHz
   localparam int CLK_PERIOD_NS      = 10;             // Clock period in ns
   localparam int PWR_TIME_MS        = 160;            // Over-power fault timer, ms
   localparam int FDR_TIME_MS        = 1500;           // Fault recovery interval, ms
   localparam int GATE_CHECK_US      = 10;             // HV gate settle check delay, us
   localparam int FIRST_SI_US        = 2;              // First pulse limit, silicon, us
   localparam int FIRST_GAN_HI_US    = 2;              // First pulse limit, GaN, big resistor
   localparam int FIRST_GAN_LO_US    = 1;              // First pulse limit, GaN, small resistor
   localparam int FAULT_PULSES       = 3;              // Consecutive pulses to trip
   // Cycle counts derived from the times
   localparam int PWR_CYCLES         = PWR_TIME_MS * 1000 * CLK_MHZ;
   localparam int FDR_CYCLES         = FDR_TIME_MS * 1000 * CLK_MHZ;
   localparam int GATE_CHECK_CYCLES  = GATE_CHECK_US * CLK_MHZ;
   localparam int FIRST_SI_CYCLES    = FIRST_SI_US * CLK_MHZ;
   localparam int FIRST_GAN_HI_CYC   = FIRST_GAN_HI_US * CLK_MHZ;
   localparam int FIRST_GAN_LO_CYC   = FIRST_GAN_LO_US * CLK_MHZ;
   localparam int CNT_W              = 32;             // Width of long timers

   // Supervisor states
   typedef enum logic [2:0] {
      CFS_OFF, CFS_CHECK, CFS_RUN, CFS_UV_CYCLE, CFS_RECOVERY
   } cfs_state_t;

   // Comparator verdicts sampled at the end of each low-side pulse
   typedef struct packed {
      logic over_current;   // Sense above 1.2 V after blanking, before demag end
      logic hv_over_volt;   // HV sense gate at or above 13.8 V
   } cfs_pulse_flags_t;

   // Startup pin checks
   typedef struct packed {
      logic gate_below_12v; // HV sense gate pin below 12 V
      logic mag_pin_fault;  // Magnetizing setting pin open or short
      logic zvd_pin_fault;  // Zero-volt delay setting pin open or short
   } cfs_pin_checks_t;
endpackage : cfs_pkg

// *** design/cfs_pulse_counter.sv ***
// Consecutive-pulse fault counter: counts pulses with the condition, clears on a clean one.
// Assumes pulse_end is a one-cycle strobe at the close of each low-side gate pulse.
`timescale 1ns/100ps
module cfs_pulse_counter
   import cfs_pkg::*;
#(
   parameter int LIMIT = FAULT_PULSES        // Pulses needed to trip
) (
   input  wire logic clk,                    // System clock
   input  wire logic nrst,                   // Async reset, active low
   input  wire logic clear,                  // Restart counting (new start)
   input  wire logic pulse_end,              // End of a low-side pulse
   input  wire logic cond,                   // Fault condition in that pulse
   output logic      trip                    // Level: limit reached
);
   // Refuse limits that the four-bit run counter cannot hold
   if (LIMIT < 1 || LIMIT > 15) begin : g_bad_limit
      $error("LIMIT out of range");
   end

   logic [3:0] count;                        // Consecutive faulty pulses

   // Count faulty pulses; a clean pulse resets the run
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count <= 4'h0;
      end else if (clear) begin
         count <= 4'h0;
      end else if (pulse_end) begin
         if (!cond) begin
            count <= 4'h0;
         end else if (count < 4'(LIMIT)) begin
            count <= count + 4'h1;
         end
      end
   end

   assign trip = (count >= 4'(LIMIT));

   AST_CLEAN_CLEARS: assert property (@(posedge clk) disable iff (!nrst)
      (pulse_end && !cond && !clear) |=> (count == 4'h0))
      else $error("Counter not cleared by clean pulse");
endmodule : cfs_pulse_counter

// *** design/cfs_supervisor.sv ***
// Top of the converter fault supervisor: state machine, long timers, pulse checks.
// Assumes comparator verdicts and supply thresholds are clean and synchronous to clk.
//
// Function
// - Peak limit hit starts over-power timer
// - Supply off with short signs: recover immediately
// - Supply off otherwise: plain undervoltage restart
// - Three over-current pulses: stop, disable, recover
// - Recovery: no gate pulses, supply cycling only
// - After recovery, restart at next turn-on
// - Over-temperature starts undervoltage restart cycle
// - Still hot after cycle: repeat it
// - First pulse over limit: recovery (silicon)
// - GaN limit depends on setting resistor
// - Open sense pin: three pulses, recover
// - HV gate quickly below 12V: undervoltage reset
// - Three HV gate overvoltage pulses: undervoltage reset
// - Setting pin open/short: immediate undervoltage reset
// - Over-power for 160 ms: recovery, no switching
// - HV gate overvoltage checked every cycle
`timescale 1ns/100ps
module cfs_supervisor
   import cfs_pkg::*;
#(
   parameter int PWR_CNT = PWR_CYCLES,       // Over-power timer length, cycles
   parameter int FDR_CNT = FDR_CYCLES        // Recovery interval, cycles
) (
   input  wire logic             clk,              // 100 MHz clock
   input  wire logic             nrst,             // Async reset, active low
   input  wire logic             vdd_on,           // Supply at turn-on threshold
   input  wire logic             vdd_off,          // Supply at turn-off threshold
   input  wire logic             gate_req,         // Low-side pulse request from PWM
   input  wire logic             peak_limit,       // Peak current limit reached
   input  wire logic             over_power,       // Sense above over-power threshold
   input  wire logic             vsense_below_0v6, // Voltage sense pin below 0.6 V
   input  wire logic             over_temp,        // Die temperature flag
   input  wire logic             si_mode,          // Select pin high: silicon mode
   input  wire logic             res_high,         // Setting resistor >= threshold
   input  wire cfs_pulse_flags_t pulse_flags,      // Per-pulse comparator verdicts
   input  wire cfs_pin_checks_t  pin_checks,       // Startup pin checks
   output logic                  low_side_gate_pulse, // Gate pulse out
   output logic                  driver_enable,    // Driver enable
   output logic                  uv_cycle_req,     // Request supply undervoltage cycle
   output logic                  recovery_active   // Long recovery in progress
);
   // Recovery must outlast the eight-cycle hold check below
   if (PWR_CNT < 1 || FDR_CNT < 9) begin : g_bad_timers
      $error("Timer counts out of range");
   end

   cfs_state_t       state;                  // Supervisor state
   logic [CNT_W-1:0] timer;                  // Shared long timer
   logic [CNT_W-1:0] pwr_timer;              // Over-power run timer
   logic             pwr_running;            // Over-power timer armed
   logic [15:0]      on_time;                // First pulse on-time
   logic             first_pulse;            // Still on first pulse since start
   logic             gate_d;                 // Last gate value, edge detect
   logic             pulse_end;              // Falling edge of gate
   logic             oc_trip;                // Over-current trip level
   logic             ov_trip;                // HV overvoltage trip level
   logic             start_clear;            // Counters restart on each start
   logic [15:0]      first_limit;            // Selected first-pulse limit

   // Falling gate marks pulse end
   assign pulse_end   = gate_d && !low_side_gate_pulse;
   assign start_clear = (state != CFS_RUN);

   // First-pulse limit choice: one mux, cheaper than separate comparators
   always_comb begin
      if (si_mode) begin
         first_limit = 16'(FIRST_SI_CYCLES);
      end else if (res_high) begin
         first_limit = 16'(FIRST_GAN_HI_CYC);
      end else begin
         first_limit = 16'(FIRST_GAN_LO_CYC);
      end
   end

   // Over-current and open sense pin share the 1.2 V verdict
   cfs_pulse_counter #(.LIMIT(FAULT_PULSES)) u_oc (
      .clk       (clk),
      .nrst      (nrst),
      .clear     (start_clear),
      .pulse_end (pulse_end),
      .cond      (pulse_flags.over_current),
      .trip      (oc_trip)
   );

   // HV gate overvoltage checked every switching cycle
   cfs_pulse_counter #(.LIMIT(FAULT_PULSES)) u_ov (
      .clk       (clk),
      .nrst      (nrst),
      .clear     (start_clear),
      .pulse_end (pulse_end),
      .cond      (pulse_flags.hv_over_volt),
      .trip      (ov_trip)
   );

   // Gate delay for edge detection
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gate_d <= 1'b0;
      end else begin
         gate_d <= low_side_gate_pulse;
      end
   end

   // First pulse on-time measurement; only the first pulse after start counts
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         on_time     <= 16'h0000;
         first_pulse <= 1'b1;
      end else if (state != CFS_RUN) begin
         on_time     <= 16'h0000;
         first_pulse <= 1'b1;
      end else if (pulse_end) begin
         first_pulse <= 1'b0;
      end else if (first_pulse && low_side_gate_pulse && on_time != 16'hFFFF) begin
         on_time <= on_time + 16'h0001;
      end
   end

   // Over-power timer: runs while sense stays above threshold or peak limit hit
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pwr_timer   <= '0;
         pwr_running <= 1'b0;
      end else if (state != CFS_RUN) begin
         pwr_timer   <= '0;
         pwr_running <= 1'b0;
      end else if (peak_limit || over_power) begin
         pwr_running <= 1'b1;
         pwr_timer   <= pwr_timer + 1'b1;
      end else begin
         pwr_timer   <= '0;                    // Must be continuous
         pwr_running <= 1'b0;
      end
   end

   // Main sequence; supply-off checks take priority over per-pulse trips
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= CFS_OFF;
         timer <= '0;
      end else begin
         unique case (state)
            CFS_OFF: begin
               if (vdd_on) begin
                  state <= CFS_CHECK;
                  timer <= '0;
               end
            end
            CFS_CHECK: begin
               if (pin_checks.mag_pin_fault || pin_checks.zvd_pin_fault) begin
                  state <= CFS_UV_CYCLE;
               end else if (over_temp) begin
                  state <= CFS_UV_CYCLE;
               end else if (timer >= CNT_W'(GATE_CHECK_CYCLES)) begin
                  if (pin_checks.gate_below_12v) begin
                     state <= CFS_UV_CYCLE;
                  end else begin
                     state <= CFS_RUN;
                  end
               end else begin
                  timer <= timer + 1'b1;
               end
            end
            CFS_RUN: begin
               if (vdd_off) begin
                  if (over_power || vsense_below_0v6) begin
                     state <= CFS_RECOVERY;
                     timer <= '0;
                  end else begin
                     state <= CFS_UV_CYCLE;
                  end
               end else if (oc_trip) begin
                  state <= CFS_RECOVERY;
                  timer <= '0;
               end else if (pwr_timer >= CNT_W'(PWR_CNT)) begin
                  state <= CFS_RECOVERY;
                  timer <= '0;
               end else if (pulse_end && on_time > first_limit && first_pulse) begin
                  state <= CFS_RECOVERY;
                  timer <= '0;
               end else if (ov_trip) begin
                  state <= CFS_UV_CYCLE;
               end else if (over_temp) begin
                  state <= CFS_UV_CYCLE;
               end
            end
            CFS_UV_CYCLE: begin
               if (vdd_off) begin
                  state <= CFS_OFF;            // Wait for next turn-on
               end
            end
            CFS_RECOVERY: begin
               if (timer >= CNT_W'(FDR_CNT - 1)) begin
                  state <= CFS_OFF;
               end else begin
                  timer <= timer + 1'b1;
               end
            end
         endcase
      end
   end

   // Outputs from flops; gate only passes in run state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         low_side_gate_pulse <= 1'b0;
         driver_enable       <= 1'b0;
         uv_cycle_req        <= 1'b0;
         recovery_active     <= 1'b0;
      end else begin
         low_side_gate_pulse <= (state == CFS_RUN) && gate_req;
         driver_enable       <= (state == CFS_RUN);
         uv_cycle_req        <= (state == CFS_UV_CYCLE) || (state == CFS_RECOVERY);
         recovery_active     <= (state == CFS_RECOVERY);
      end
   end

   AST_NO_GATE_IN_RECOVERY: assert property (@(posedge clk) disable iff (!nrst)
      (state == CFS_RECOVERY) |=> !low_side_gate_pulse)
      else $error("Gate pulse during recovery");
   AST_OC_TO_RECOVERY: assert property (@(posedge clk) disable iff (!nrst)
      (state == CFS_RUN && oc_trip && !vdd_off) |=> state == CFS_RECOVERY)
      else $error("Over-current did not start recovery");
   AST_DRV_LOW_AFTER_OC: assert property (@(posedge clk) disable iff (!nrst)
      (state == CFS_RUN && oc_trip && !vdd_off) |=> ##1 !driver_enable)
      else $error("Driver enable not dropped");
   AST_SHORT_AT_OFF: assert property (@(posedge clk) disable iff (!nrst)
      (state == CFS_RUN && vdd_off && (over_power || vsense_below_0v6))
      |=> state == CFS_RECOVERY)
      else $error("Short at supply off not recovered");
   AST_PLAIN_OFF: assert property (@(posedge clk) disable iff (!nrst)
      (state == CFS_RUN && vdd_off && !over_power && !vsense_below_0v6)
      |=> state == CFS_UV_CYCLE)
      else $error("Plain supply off not a UV cycle");
   AST_PIN_FAULT: assert property (@(posedge clk) disable iff (!nrst)
      (state == CFS_CHECK && (pin_checks.mag_pin_fault || pin_checks.zvd_pin_fault))
      |=> state == CFS_UV_CYCLE)
      else $error("Setting pin fault not reset");
   AST_HOT_RUN: assert property (@(posedge clk) disable iff (!nrst)
      (state == CFS_RUN && over_temp && !vdd_off && !oc_trip && !ov_trip
       && pwr_timer < CNT_W'(PWR_CNT) && !pulse_end) |=> state == CFS_UV_CYCLE)
      else $error("Over-temperature ignored");
   AST_RECOVERY_HOLDS: assert property (@(posedge clk) disable iff (!nrst)
      $rose(recovery_active) |=> recovery_active [*8])
      else $error("Recovery ended too soon");
   AST_PWR_ARMS: assert property (@(posedge clk) disable iff (!nrst)
      (state == CFS_RUN && peak_limit) |=> (pwr_running || state != CFS_RUN))
      else $error("Over-power timer not armed");

   COV_RECOVERY: cover property (@(posedge clk) disable iff (!nrst)
      state == CFS_RUN ##1 state == CFS_RECOVERY);
   COV_UV: cover property (@(posedge clk) disable iff (!nrst)
      state == CFS_RUN ##1 state == CFS_UV_CYCLE);
   COV_RESTART: cover property (@(posedge clk) disable iff (!nrst)
      state == CFS_RECOVERY ##1 state == CFS_OFF);
endmodule : cfs_supervisor

// *** testbench/cfs_stage_model.sv ***
// Power stage model: answers each low-side gate pulse with comparator verdicts.
// Assumes the bench chooses the faults that the stage shows through oc_mode and ov_mode.
`timescale 1ns/100ps
module cfs_stage_model
   import cfs_pkg::*;
(
   input  wire logic        clk,      // System clock
   input  wire logic        gate,     // Low-side gate pulse from the supervisor
   input  wire logic        oc_mode,  // Stage shows sense above 1.2 V
   input  wire logic        ov_mode,  // Stage shows HV gate overvoltage
   output cfs_pulse_flags_t flags,    // Verdicts handed back
   output int               pulses    // Gate pulses seen so far
);
   logic gate_d = 1'b0;               // Gate one cycle late
   logic wobble = 1'b0;               // Junk pattern outside pulses
   int   seen   = 0;                  // Rising edges counted so far, one driver only
   assign pulses = seen;
   // Count rising edges, so a pulse sent during recovery cannot hide
   always @(posedge clk) begin
      gate_d <= gate;
      wobble <= ~wobble;
      if (gate && !gate_d) begin
         seen <= seen + 1;
      end
   end
   // Verdicts hold over a pulse and its falling edge; elsewhere they toggle
   assign flags = (gate || gate_d) ? {oc_mode, ov_mode} : {wobble, ~wobble};
endmodule : cfs_stage_model

// *** testbench/cfs_supervisor_bench.sv ***
// Self-checking bench for the fault supervisor with a power stage model.
// Assumes short long-timer parameters; startup check still takes 1000 cycles.
`timescale 1ns/100ps
module cfs_supervisor_bench;
   import cfs_pkg::*;
   localparam int PWR = 50;                 // Short over-power timer
   localparam int FDR = 100;                // Short recovery interval
   logic clk = 1'b0, nrst = 1'b0, vdd_on = 1'b0, vdd_off = 1'b0, gate_req = 1'b0;
   logic peak_limit = 1'b0, over_power = 1'b0, vsense_below_0v6 = 1'b0, over_temp = 1'b0;
   logic si_mode = 1'b1, res_high = 1'b1, oc_mode = 1'b0, ov_mode = 1'b0;
   cfs_pin_checks_t  pin_checks = '0;       // Startup pin verdicts
   cfs_pulse_flags_t flags;                 // From the stage model
   logic             gate, den, uvr, rec;   // Design outputs
   logic [3:0]       outs;                  // {gate, enable, uv request, recovery}
   int               pulses, mismatches = 0, comparisons = 0;
   assign outs = {gate, den, uvr, rec};
   // 100 MHz clock
   always #5 clk = ~clk;
   cfs_supervisor #(.PWR_CNT(PWR), .FDR_CNT(FDR)) cfs_supervisor_inst (
      .clk(clk), .nrst(nrst), .vdd_on(vdd_on), .vdd_off(vdd_off), .gate_req(gate_req),
      .peak_limit(peak_limit), .over_power(over_power),
      .vsense_below_0v6(vsense_below_0v6),
      .over_temp(over_temp), .si_mode(si_mode), .res_high(res_high),
      .pulse_flags(flags), .pin_checks(pin_checks), .low_side_gate_pulse(gate),
      .driver_enable(den), .uv_cycle_req(uvr), .recovery_active(rec));
   cfs_stage_model cfs_stage_model_inst (.clk(clk), .gate(gate), .oc_mode(oc_mode),
      .ov_mode(ov_mode), .flags(flags), .pulses(pulses));
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   // Bounded wait on masked outputs; running out ends the run
   task automatic wait_for(input string what, input logic [3:0] m, input logic [3:0] w,
                           input int lim);
      for (int i = 0; i < lim; i++) begin
         @(posedge clk);
         #1;
         if ((outs & m) === w) break;
      end
      check(what, outs & m, w);
      if ((outs & m) !== w) results();
      // Hand back on a rising edge so that the next drive lands on one
      @(posedge clk);
   endtask : wait_for
   // Reset for 3 cycles with quiet inputs, then one turn-on strobe
   task automatic power_up();
      @(posedge clk);
      nrst <= 1'b0;
      {peak_limit, over_power, vsense_below_0v6, over_temp, oc_mode, ov_mode} <= '0;
      {si_mode, res_high, pin_checks, gate_req, vdd_off} <= 7'h60;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      vdd_on <= 1'b1;
      @(posedge clk);
      vdd_on <= 1'b0;
   endtask : power_up
   task automatic strobe_off();
      @(posedge clk);
      vdd_off <= 1'b1;
      @(posedge clk);
      vdd_off <= 1'b0;
   endtask : strobe_off
   // One gate request of n cycles, then a short quiet gap
   task automatic pulse(input int n);
      @(posedge clk);
      gate_req <= 1'b1;
      repeat (n) @(posedge clk);
      gate_req <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : pulse
   task automatic run_up();
      power_up();
      wait_for("run", 4'h6, 4'h4, 1010);
   endtask : run_up
   // Each pin fault at turn-on: undervoltage reset, no enable
   task automatic t_pins();
      for (int k = 0; k < 3; k++) begin
         power_up();
         pin_checks <= cfs_pin_checks_t'(3'h1 << k);
         wait_for("pin fault", 4'h6, 4'h2, (k == 2) ? 1100 : 10);
      end
   endtask : t_pins
   // Broken run of over-current pulses, then three in a row, then recovery
   task automatic t_oc();
      int seen;
      run_up();
      oc_mode <= 1'b1;
      repeat (2) pulse(5);
      oc_mode <= 1'b0;
      pulse(5);
      oc_mode <= 1'b1;
      repeat (2) pulse(5);
      #1;
      check("no trip", outs, 4'h4);
      check("pulses sent", pulses, 5);
      pulse(5);
      wait_for("oc trip", 4'h5, 4'h1, 5);
      seen = pulses;
      gate_req <= 1'b1;
      wait_for("recovery end", 4'h3, 4'h0, FDR + 5);
      check("recovery pulses", pulses, seen);
      gate_req <= 1'b0;
      @(posedge clk);
      vdd_on <= 1'b1;
      @(posedge clk);
      vdd_on <= 1'b0;
      wait_for("restart", 4'h6, 4'h4, 1010);
   endtask : t_oc
   task automatic t_ov();
      run_up();
      ov_mode <= 1'b1;
      repeat (3) pulse(5);
      wait_for("ov trip", 4'h7, 4'h2, 5);
   endtask : t_ov
   // Supply loss plain, with over-power, with low voltage sense
   task automatic t_vdd();
      for (int k = 0; k < 3; k++) begin
         run_up();
         over_power <= (k == 1);
         vsense_below_0v6 <= (k == 2);
         strobe_off();
         wait_for("supply off", 4'h7, (k == 0) ? 4'h2 : 4'h3, 5);
      end
   endtask : t_vdd
   // Timer must restart after a gap, then trip after a full run
   task automatic t_power();
      run_up();
      peak_limit <= 1'b1;
      repeat (PWR - 10) @(posedge clk);
      peak_limit <= 1'b0;
      @(posedge clk);
      over_power <= 1'b1;
      repeat (PWR - 10) @(posedge clk);
      #1;
      check("power gap", outs & 4'h5, 4'h4);
      wait_for("power trip", 4'h5, 4'h1, 20);
   endtask : t_power
   task automatic t_temp();
      run_up();
      over_temp <= 1'b1;
      wait_for("hot", 4'h6, 4'h2, 5);
      strobe_off();
      wait_for("hot off", 4'h2, 4'h0, 5);
      @(posedge clk);
      vdd_on <= 1'b1;
      @(posedge clk);
      vdd_on <= 1'b0;
      wait_for("still hot", 4'h6, 4'h2, 10);
   endtask : t_temp
   // First pulse limit per mode; only the first pulse is measured
   task automatic t_first();
      int lim;
      for (int k = 0; k < 6; k++) begin
         lim = (k / 2 == 0) ? FIRST_SI_CYCLES : (k / 2 == 1) ? FIRST_GAN_HI_CYC : FIRST_GAN_LO_CYC;
         power_up();
         si_mode <= (k / 2 == 0);
         res_high <= (k / 2 == 1);
         wait_for("run", 4'h6, 4'h4, 1010);
         // Exactly at the limit must pass, one cycle over must trip
         pulse(k[0] ? lim + 1 : lim);
         #1;
         check("first pulse", rec, k[0]);
         if (!k[0]) begin
            pulse(lim + 1);
            #1;
            check("second pulse", rec, 1'b0);
         end
      end
   endtask : t_first
   // Main sequence
   initial begin
      t_pins();
      t_oc();
      t_ov();
      t_vdd();
      t_power();
      t_temp();
      t_first();
      results();
   end
endmodule : cfs_supervisor_bench
